/* verilog/adc_ctrl_regs.svh */
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ****************************************************************
// Register byte offsets on the AHB-Lite slave
// ****************************************************************
`define CTRL_OFFSET          8'h00
`define STATUS_OFFSET        8'h04
`define RESULT_OFFSET        8'h08
`define INT_STATUS_OFFSET    8'h0c
`define INT_MASK_OFFSET      8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_STANDALONE_BIT  0
`define STATUS_BUSY_BIT      0
`define STATUS_SHORT_BIT     1
`define STATUS_FMT12_BIT     2
`define INT_DONE_BIT         0
`define INT_IGNORED_BIT      1
`define INT_WIDTH            2

// ****************************************************************
// Reset values
// ****************************************************************
`define CTRL_RESET           1'b0
`define INT_MASK_RESET       2'h0
`define RESULT_RESET         12'h000

// ****************************************************************
// Conversion sequence constants
// ****************************************************************
`define RESULT_MSB_INDEX     4'hb
`define FULL_LAST_INDEX      4'h0
`define SHORT_LAST_INDEX     4'h4

// ****************************************************************
// Timing: trial rate and the clock rate, in MHz
// ****************************************************************
`define CLK_RATE_MHZ         250
`define TRIAL_RATE_MHZ       1
`define TRIAL_CYCLES         (`CLK_RATE_MHZ / `TRIAL_RATE_MHZ)

`endif

/* verilog/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

    // ****************************************************************
    // Control section states
    // ****************************************************************
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b01,
        CTL_CONV = 2'b10
    } ctl_state_t;

    // ****************************************************************
    // Approximation register states
    // ****************************************************************
    typedef enum logic [2:0] {
        SAR_IDLE  = 3'b001,
        SAR_ARM   = 3'b010,
        SAR_TRIAL = 3'b100
    } sar_state_t;

    typedef logic [11:0] result_t;

endpackage

/* verilog/sar_sequencer.sv */
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"

module sar_sequencer (
    // Clock and reset
    input  logic                  clk,
    input  logic                  rst_n,
    // Control
    input  logic                  start,
    input  logic                  short_cycle,
    input  logic                  tick,
    // Comparator: DAC sum below the input
    input  logic                  comp_below,
    // Trial code and completion
    output adc_ctrl_pkg::result_t trial_code,
    output logic                  done,
    output logic                  busy
);

    adc_ctrl_pkg::sar_state_t state;
    adc_ctrl_pkg::result_t    sar;
    logic [3:0]               ptr;
    logic [3:0]               last;
    logic [3:0]               next_ptr;

    assign next_ptr   = ptr - 4'h1;
    assign trial_code = sar;
    assign busy       = (state != adc_ctrl_pkg::SAR_IDLE);

    // ****************************************************************
    // Bit trial sequence, one step per trial tick
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= adc_ctrl_pkg::SAR_IDLE;
            sar   <= 12'h000;
            ptr   <= 4'h0;
            last  <= 4'h0;
            done  <= 1'b0;
        end else begin
            case (state)
                adc_ctrl_pkg::SAR_IDLE: begin
                    done <= 1'b0;
                    if (start) begin
                        sar   <= 12'h000;                   // R05
                        ptr   <= `RESULT_MSB_INDEX;         // R09
                        last  <= short_cycle ? `SHORT_LAST_INDEX
                                             : `FULL_LAST_INDEX; // R16
                        state <= adc_ctrl_pkg::SAR_ARM;
                    end
                end
                adc_ctrl_pkg::SAR_ARM: begin
                    if (tick) begin
                        sar[ptr] <= 1'b1;                   // R09
                        state    <= adc_ctrl_pkg::SAR_TRIAL;
                    end
                end
                adc_ctrl_pkg::SAR_TRIAL: begin
                    if (tick) begin
                        // Keep the bit only while the sum stays below the input
                        if (!comp_below) begin
                            sar[ptr] <= 1'b0;               // R10
                        end
                        if (ptr == last) begin
                            done  <= 1'b1;                  // R11
                            state <= adc_ctrl_pkg::SAR_IDLE;
                        end else begin
                            sar[next_ptr] <= 1'b1;          // R09
                            ptr           <= next_ptr;
                        end
                    end
                end
                default: begin
                    state <= adc_ctrl_pkg::SAR_IDLE;
                end
            endcase
        end
    end

endmodule

/* verilog/adc_conv_ctrl.sv */
// Contract
// (R01) Read/convert high reads, low converts
// (R02) Standalone: falling read/convert edge starts conversion
// (R03) Status high during conversion, low after
// (R04) Format low: two bytes; high: 12-bit word
// (R05) Start enables clock, clears approximation register
// (R06) Starts ignored while a conversion runs
// (R07) No result driven while converting
// (R08) End stops clock, re-enables reads
// (R09) Trials run from MSB toward LSB
// (R10) Keep bit if below, clear if above
// (R11) Final code becomes the readable result
// (R12) One bit trial per microsecond
// (R13) Byte address low: 12-bit, high: 8-bit
// (R14) Byte read: high bits or low nibble+zeros
// (R15) Act only with enable and select asserted
// (R16) Short cycle: eight trials, low bits clear
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"

module adc_conv_ctrl (
    // Clock and reset
    input  logic        CLK,
    input  logic        RST_N,
    // Host control pins
    input  logic        CHIP_EN,
    input  logic        CHIP_SEL_N,
    input  logic        READ_CONVERT,
    input  logic        BYTE_ADDR_SHORT_CYCLE,
    input  logic        WORD_FMT_12,
    // Comparator and DAC
    input  logic        COMP_BELOW,
    output logic [11:0] DAC_CODE,
    // Result data lines and status
    output logic [11:0] RESULT_DATA_LINES,
    output logic [11:0] RESULT_DATA_LINES_OE,
    output logic        CONVERSION_STATUS,
    // AHB-Lite slave
    input  logic        HSEL,
    input  logic [31:0] HADDR,
    input  logic [1:0]  HTRANS,
    input  logic        HWRITE,
    input  logic [2:0]  HSIZE,
    input  logic [31:0] HWDATA,
    input  logic        HREADY,
    output logic [31:0] HRDATA,
    output logic        HREADYOUT,
    output logic        HRESP,
    // Interrupt
    output logic        IRQ
);

    localparam logic [7:0] TRIAL_LAST = 8'(`TRIAL_CYCLES - 1);

    adc_ctrl_pkg::ctl_state_t state;
    adc_ctrl_pkg::result_t    result;
    adc_ctrl_pkg::result_t    trial_code;
    logic                     standalone;
    logic                     short_cycle;
    logic                     read_convert_q;
    logic                     conv_req_q;
    logic                     selected;
    logic                     conv_req;
    logic                     start_cmd;
    logic                     start;
    logic                     ignored;
    logic                     read_active;
    logic [7:0]               tick_cnt;
    logic                     tick;
    logic                     sar_done;
    logic                     sar_busy;
    logic [`INT_WIDTH-1:0]    int_status;
    logic [`INT_WIDTH-1:0]    int_mask;
    logic [`INT_WIDTH-1:0]    int_event;
    logic [`INT_WIDTH-1:0]    int_clear;
    logic                     wr_pend;
    logic [7:0]               wr_addr;
    logic                     bus_take;
    logic [31:0]              next_hrdata;
    logic [11:0]              next_data;
    logic [11:0]              next_oe;

    // ****************************************************************
    // Start command decode
    // ****************************************************************

    // Enable and select gate every operation
    assign selected = CHIP_EN && !CHIP_SEL_N;                       // R15
    assign conv_req = selected && !READ_CONVERT;                    // R01

    // Full control starts on entry into convert; standalone on falling edge
    assign start_cmd = standalone ? (selected && read_convert_q && !READ_CONVERT) // R02
                                  : (conv_req && !conv_req_q);      // R01
    assign start   = start_cmd && (state == adc_ctrl_pkg::CTL_IDLE);
    assign ignored = start_cmd && (state != adc_ctrl_pkg::CTL_IDLE); // R06

    // Previous pin levels for edge detection
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            read_convert_q <= 1'b1;
            conv_req_q     <= 1'b0;
        end else begin
            read_convert_q <= READ_CONVERT;
            conv_req_q     <= conv_req;
        end
    end

    // ****************************************************************
    // Control section
    // ****************************************************************

    // Idle until started, back to idle on end of conversion
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state       <= adc_ctrl_pkg::CTL_IDLE;
            short_cycle <= 1'b0;
        end else begin
            case (state)
                adc_ctrl_pkg::CTL_IDLE: begin
                    if (start) begin
                        short_cycle <= BYTE_ADDR_SHORT_CYCLE;   // R13
                        state       <= adc_ctrl_pkg::CTL_CONV;
                    end
                end
                adc_ctrl_pkg::CTL_CONV: begin
                    // Runs to completion; no abort path exists
                    if (sar_done) begin                         // R06
                        state <= adc_ctrl_pkg::CTL_IDLE;        // R08
                    end
                end
                default: begin
                    state <= adc_ctrl_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    // Status pin follows the conversion cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CONVERSION_STATUS <= 1'b0;
        end else if (start) begin
            CONVERSION_STATUS <= 1'b1;                          // R03
        end else if (sar_done) begin
            CONVERSION_STATUS <= 1'b0;                          // R03
        end
    end

    // ****************************************************************
    // Gated trial clock divider
    // ****************************************************************

    // Counts only while converting; restarts on every start
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_cnt <= 8'h00;
            tick     <= 1'b0;
        end else if (start || state != adc_ctrl_pkg::CTL_CONV || sar_done) begin
            tick_cnt <= 8'h00;                                  // R05 R08
            tick     <= 1'b0;
        end else if (tick_cnt == TRIAL_LAST) begin
            tick_cnt <= 8'h00;
            tick     <= 1'b1;                                   // R12
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
            tick     <= 1'b0;
        end
    end

    // ****************************************************************
    // Approximation register
    // ****************************************************************
    sar_sequencer u_sar (
        .clk         (CLK),
        .rst_n       (RST_N),
        .start       (start),
        .short_cycle (BYTE_ADDR_SHORT_CYCLE),
        .tick        (tick),
        .comp_below  (COMP_BELOW),
        .trial_code  (trial_code),
        .done        (sar_done),
        .busy        (sar_busy)
    );

    // Trial code to the DAC, final code to the result
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DAC_CODE <= 12'h000;
            result   <= `RESULT_RESET;
        end else begin
            DAC_CODE <= trial_code;
            if (sar_done) begin
                result <= trial_code;                           // R11
            end
        end
    end

    // ****************************************************************
    // Result output buffers
    // ****************************************************************
    assign read_active = selected && READ_CONVERT
                         && state == adc_ctrl_pkg::CTL_IDLE && !start; // R07 R08

    // Format and byte select choose the driven lines
    always_comb begin
        next_data = 12'h000;
        next_oe   = 12'h000;
        if (read_active) begin                                  // R01
            if (WORD_FMT_12) begin
                next_data = result;                             // R04
                next_oe   = 12'hfff;
            end else if (!BYTE_ADDR_SHORT_CYCLE) begin
                next_data = {result[11:4], 4'h0};               // R14
                next_oe   = 12'hff0;
            end else begin
                next_data = {4'h0, 4'h0, result[3:0]};          // R14
                next_oe   = 12'h0ff;
            end
        end
    end

    // Registered buffer drive
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RESULT_DATA_LINES    <= 12'h000;
            RESULT_DATA_LINES_OE <= 12'h000;
        end else begin
            RESULT_DATA_LINES    <= next_data;
            RESULT_DATA_LINES_OE <= next_oe;                    // R04 R07
        end
    end

    // ****************************************************************
    // Interrupt status and line
    // ****************************************************************
    assign int_event = {ignored, sar_done};
    assign int_clear = (wr_pend && wr_addr == `INT_STATUS_OFFSET)
                       ? HWDATA[`INT_WIDTH-1:0] : {`INT_WIDTH{1'b0}};

    // Sticky bits; a new event wins over a clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_status <= {`INT_WIDTH{1'b0}};
        end else begin
            int_status <= (int_status & ~int_clear) | int_event;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_status & int_mask);
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    assign bus_take = HSEL && HTRANS[1] && HREADY;

    // Zero wait states, always OKAY
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Address phase of a write held for its data phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= bus_take && HWRITE && HSIZE == 3'h2;
            wr_addr <= HADDR[7:0];
        end
    end

    // Writable registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            standalone <= `CTRL_RESET;
            int_mask   <= `INT_MASK_RESET;
        end else if (wr_pend) begin
            if (wr_addr == `CTRL_OFFSET) begin
                standalone <= HWDATA[`CTRL_STANDALONE_BIT];
            end
            if (wr_addr == `INT_MASK_OFFSET) begin
                int_mask <= HWDATA[`INT_WIDTH-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (HADDR[7:0])
            `CTRL_OFFSET: begin
                next_hrdata[`CTRL_STANDALONE_BIT] = standalone;
            end
            `STATUS_OFFSET: begin
                next_hrdata[`STATUS_BUSY_BIT]  = sar_busy;
                next_hrdata[`STATUS_SHORT_BIT] = short_cycle;
                next_hrdata[`STATUS_FMT12_BIT] = WORD_FMT_12;
            end
            `RESULT_OFFSET: begin
                next_hrdata[11:0] = result;
            end
            `INT_STATUS_OFFSET: begin
                next_hrdata[`INT_WIDTH-1:0] = int_status;
            end
            `INT_MASK_OFFSET: begin
                next_hrdata[`INT_WIDTH-1:0] = int_mask;
            end
            default: begin
                next_hrdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data registered into the data phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_take && !HWRITE) begin
            HRDATA <= next_hrdata;
        end
    end

endmodule

/* tb/adc_conv_ctrl_monitor.sv */
`timescale 1ns/100ps

// ****************************************************************
// Pin and bus checker
// ****************************************************************
module adc_conv_ctrl_monitor (
    // Clock and reset
    input logic        CLK,
    input logic        RST_N,
    // Host pins
    input logic        CHIP_EN,
    input logic        CHIP_SEL_N,
    input logic        READ_CONVERT,
    input logic        BYTE_ADDR_SHORT_CYCLE,
    input logic        WORD_FMT_12,
    // Converter outputs
    input logic [11:0] DAC_CODE,
    input logic [11:0] RESULT_DATA_LINES,
    input logic [11:0] RESULT_DATA_LINES_OE,
    input logic        CONVERSION_STATUS,
    input logic        HREADYOUT,
    input logic        HRESP
);
    logic [11:0] busy_len;
    logic        ba_d;
    logic        short_q;
    wire         rd_cond = CHIP_EN && !CHIP_SEL_N && READ_CONVERT;
    wire         cv_cond = CHIP_EN && !CHIP_SEL_N && !READ_CONVERT;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Busy cycle count and length class at start
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_len <= 12'h000;
            ba_d     <= 1'b0;
            short_q  <= 1'b0;
        end else begin
            busy_len <= CONVERSION_STATUS ? busy_len + 12'h001 : 12'h000;
            ba_d     <= BYTE_ADDR_SHORT_CYCLE;
            if (CONVERSION_STATUS && busy_len == 12'h000) begin
                short_q <= ba_d;
            end
        end
    end

    start_needs_pins_a: assert property ($rose(CONVERSION_STATUS) |-> $past(cv_cond))
        else $error("status rose without convert");
    no_data_busy_a: assert property (CONVERSION_STATUS && $past(CONVERSION_STATUS) |->
        RESULT_DATA_LINES_OE == 12'h000 && RESULT_DATA_LINES == 12'h000)
        else $error("data driven during conversion");
    msb_first_a: assert property ($rose(CONVERSION_STATUS) |-> ##[1:300] DAC_CODE == 12'h800)
        else $error("first trial not msb");
    full_len_a: assert property ($fell(CONVERSION_STATUS) && !short_q |->
        busy_len >= 12'd2990 && busy_len <= 12'd3270)
        else $error("full cycle length wrong");
    short_len_a: assert property ($fell(CONVERSION_STATUS) && short_q |->
        busy_len >= 12'd1990 && busy_len <= 12'd2270)
        else $error("short cycle length wrong");
    short_low_a: assert property (short_q && CONVERSION_STATUS && busy_len > 12'd4 |->
        DAC_CODE[3:0] == 4'h0)
        else $error("short cycle set low bits");
    oe_pattern_a: assert property (RESULT_DATA_LINES_OE inside {12'h000, 12'hfff, 12'hff0,
        12'h0ff} && (RESULT_DATA_LINES & ~RESULT_DATA_LINES_OE) == 12'h000)
        else $error("bad enable pattern");
    read_needs_pins_a: assert property (RESULT_DATA_LINES_OE != 12'h000 |->
        $past(rd_cond) || $past(rd_cond, 2))
        else $error("data driven without a read");
    word_fmt_a: assert property (RESULT_DATA_LINES_OE == 12'hfff |->
        $past(WORD_FMT_12) || $past(WORD_FMT_12, 2))
        else $error("word read without word format");
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready okay");

    // Main scenarios
    cover property ($fell(CONVERSION_STATUS) && short_q);
    cover property ($fell(CONVERSION_STATUS) && !short_q);
    cover property (RESULT_DATA_LINES_OE == 12'h0ff);
    cover property (RESULT_DATA_LINES_OE == 12'hfff);
endmodule

bind adc_conv_ctrl adc_conv_ctrl_monitor u_mon (.CLK, .RST_N, .CHIP_EN, .CHIP_SEL_N,
    .READ_CONVERT, .BYTE_ADDR_SHORT_CYCLE, .WORD_FMT_12, .DAC_CODE, .RESULT_DATA_LINES,
    .RESULT_DATA_LINES_OE, .CONVERSION_STATUS, .HREADYOUT, .HRESP);

/* tb/host_pins_model.sv */
`timescale 1ns/100ps

// ****************************************************************
// Host side of the control pins
// ****************************************************************
module host_pins_model (
    // Clock
    input  logic        clk,
    // Control pins
    output logic        chip_en,
    output logic        chip_sel_n,
    output logic        read_convert,
    output logic        byte_addr_short_cycle,
    output logic        word_fmt_12,
    // Result lines
    input  logic [11:0] lines,
    input  logic [11:0] lines_oe
);
    // Idle: deselected, read/convert parked high
    initial begin
        chip_en               = 1'b0;
        chip_sel_n            = 1'b1;
        read_convert          = 1'b1;
        byte_addr_short_cycle = 1'b0;
        word_fmt_12           = 1'b0;
    end

    // Convert command; read/convert settles before enable, in standalone it falls one cycle after enable
    task automatic convert(input logic alone, input logic short_c, input logic en);
        @(posedge clk);
        byte_addr_short_cycle <= short_c;
        chip_sel_n            <= 1'b0;
        read_convert          <= alone;
        @(posedge clk);
        chip_en <= en;
        if (alone) begin
            @(posedge clk);
            read_convert <= 1'b0;
        end
        @(posedge clk);
        chip_en      <= 1'b0;
        chip_sel_n   <= 1'b1;
        read_convert <= 1'b1;
    endtask

    // Read command, lines sampled once registered
    task automatic read_pins(input logic fmt12, input logic bsel, output logic [11:0] data,
                             output logic [11:0] oe);
        @(posedge clk);
        word_fmt_12           <= fmt12;
        byte_addr_short_cycle <= bsel;
        chip_sel_n            <= 1'b0;
        chip_en               <= 1'b1;
        read_convert          <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
        data = lines;
        oe   = lines_oe;
        @(posedge clk);
        chip_en    <= 1'b0;
        chip_sel_n <= 1'b1;
    endtask
endmodule

/* tb/sar_adc_conversion_control_tb_top.sv */
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: %s", $time, msg); end end

// ****************************************************************
// Testbench top
// ****************************************************************
module sar_adc_conversion_control_tb_top;
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        CHIP_EN, CHIP_SEL_N, READ_CONVERT, BYTE_ADDR_SHORT_CYCLE, WORD_FMT_12;
    logic        COMP_BELOW = 1'b0;
    logic [11:0] DAC_CODE, RESULT_DATA_LINES, RESULT_DATA_LINES_OE, dl, de;
    logic        CONVERSION_STATUS, HREADYOUT, HRESP, IRQ, HREADY;
    logic        HSEL = 1'b0, HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h0;
    int          err_count = 0, checks = 0, seed = 20154, vin = 0, expv;
    int          exp_q[$];
    int          vins[4] = '{0, 4096, 0, 0};
    int          alone_t[4] = '{0, 0, 1, 1};
    int          short_t[4] = '{0, 1, 1, 0};
    int          mask_t[4] = '{3, 3, 1, 0};
    int          offs[6] = '{0, 4, 8, 12, 16, 32};

    always #2 CLK = ~CLK;
    assign HREADY = HREADYOUT;
    // Comparator: trial code against the analog input
    always @(posedge CLK) COMP_BELOW <= (DAC_CODE < vin);

    host_pins_model hp (.clk(CLK), .chip_en(CHIP_EN), .chip_sel_n(CHIP_SEL_N),
        .read_convert(READ_CONVERT), .byte_addr_short_cycle(BYTE_ADDR_SHORT_CYCLE),
        .word_fmt_12(WORD_FMT_12), .lines(RESULT_DATA_LINES), .lines_oe(RESULT_DATA_LINES_OE));

    adc_conv_ctrl dut (.CLK, .RST_N, .CHIP_EN, .CHIP_SEL_N, .READ_CONVERT, .WORD_FMT_12,
        .BYTE_ADDR_SHORT_CYCLE, .COMP_BELOW, .DAC_CODE, .RESULT_DATA_LINES, .IRQ,
        .RESULT_DATA_LINES_OE, .CONVERSION_STATUS, .HSEL, .HADDR, .HTRANS, .HWRITE,
        .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP);

    // Reference model: keep a trial bit while below the input
    function automatic int sar_model(input int v, input int sh);
        int r;
        int t;
        r = 0;
        for (int b = 11; b >= (sh ? 4 : 0); b--) begin
            t = r | (1 << b);
            if (t < v) r = t;
        end
        return r;
    endfunction

    // Single AHB-Lite word transfer
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge CLK);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HADDR  <= {24'h0, addr};
        HWRITE <= wr;
        HSIZE  <= 3'h2;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wdata;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rdata = HRDATA;
    endtask

    task automatic complete_run();
        $display("checks %0d, err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        err_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        vins[2] = $random(seed) & 32'hfff;
        vins[3] = $random(seed) & 32'hfff;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        foreach (offs[i]) begin
            ahb(1'b0, offs[i][7:0], 32'h0, rd);
            `CHK(rd, 32'h0, "reset value")
        end
        hp.convert(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge CLK);
        #1 `CHK(CONVERSION_STATUS, 1'b0, "start without enable")
        foreach (vins[i]) begin
            vin = vins[i];
            ahb(1'b1, `CTRL_OFFSET, alone_t[i], rd);
            ahb(1'b1, `INT_MASK_OFFSET, mask_t[i], rd);
            exp_q.push_back(sar_model(vin, short_t[i]));
            hp.convert(alone_t[i][0], short_t[i][0], 1'b1);
            repeat (3) @(posedge CLK);
            #1 `CHK(CONVERSION_STATUS, 1'b1, "not busy after start")
            hp.read_pins(1'b1, 1'b0, dl, de);
            `CHK(de, 12'h000, "read while busy")
            hp.convert(alone_t[i][0], !short_t[i][0], 1'b1);
            while (CONVERSION_STATUS !== 1'b0) @(negedge CLK);
            expv = exp_q.pop_front();
            ahb(1'b0, `RESULT_OFFSET, 32'h0, rd);
            `CHK(rd, expv, "result")
            hp.read_pins(1'b1, 1'b0, dl, de);
            `CHK({de, dl}, {12'hfff, 12'(expv)}, "word read")
            hp.read_pins(1'b0, 1'b0, dl, de);
            `CHK({de, dl}, {12'hff0, 12'(expv & 'hff0)}, "high byte read")
            hp.read_pins(1'b0, 1'b1, dl, de);
            `CHK({de, dl}, {12'h0ff, 12'(expv & 'hf)}, "low nibble read")
            ahb(1'b0, `STATUS_OFFSET, 32'h0, rd);
            `CHK(rd, 32'(short_t[i] << 1), "status")
            ahb(1'b0, `INT_STATUS_OFFSET, 32'h0, rd);
            `CHK(rd, 32'h3, "event bits")
            `CHK(IRQ, 1'(mask_t[i] != 0), "irq level")
            ahb(1'b1, `INT_STATUS_OFFSET, 32'h3, rd);
            repeat (3) @(posedge CLK);
            #1 `CHK(IRQ, 1'b0, "irq after clear")
        end
        complete_run();
    end
endmodule
